// >>> pkg/palhap_consts.svh
`ifndef PALHAP_CONSTS_SVH
`define PALHAP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------------
`define PALHAP_SEL_ADDR_RAM_WR 3'h0
`define PALHAP_SEL_LUT 3'h1
`define PALHAP_SEL_MASK 3'h2
`define PALHAP_SEL_ADDR_RAM_RD 3'h3
`define PALHAP_SEL_ADDR_OVL_WR 3'h4
`define PALHAP_SEL_OVL 3'h5
`define PALHAP_SEL_CMD 3'h6
`define PALHAP_SEL_ADDR_OVL_RD 3'h7
`define PALHAP_SEL_OVL_BIT 2

// ----------------------------------------------------------------------------
// Command register fields and reset values
// ----------------------------------------------------------------------------
`define PALHAP_CMD_CHAN_HI 7
`define PALHAP_CMD_CHAN_LO 6
`define PALHAP_CMD_EIGHT_BIT 1
`define PALHAP_CMD_PEDESTAL 0
`define PALHAP_CMD_RESET 8'h00
`define PALHAP_MASK_RESET 8'hFF
`define PALHAP_INDEX_RESET 8'h00
`define PALHAP_INDEX_STEP 8'h01
`define PALHAP_INDEX_LAST 8'hFF

// ----------------------------------------------------------------------------
// Overlay and pixel format codes
// ----------------------------------------------------------------------------
`define PALHAP_OVL_NONE 4'h0
`define PALHAP_FMT_TRUE24 2'h0
`define PALHAP_FMT_BYPASS24 2'h1
`define PALHAP_FMT_PSEUDO 2'h2
`define PALHAP_FMT_BYPASS8 2'h3
`define PALHAP_CHAN_RED 2'h0
`define PALHAP_CHAN_GREEN 2'h1
`define PALHAP_CHAN_BLUE 2'h2
`define PALHAP_CHAN_WIDE15 2'h3

`endif

// >>> pkg/palhap_pkg.sv
package palhap_pkg;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } palhap_rgb_t;

  typedef enum logic [1:0] {
    PH_RED = 2'b00,
    PH_GREEN = 2'b01,
    PH_BLUE = 2'b10
  } palhap_phase_t;

  typedef struct packed {
    logic overlay;
    logic readMode;
  } palhap_mode_t;

endpackage

// >>> verilog/palhap_port.sv
// Notes on behaviour
// - Select codes pick address load, lookup RAM, overlay, mask or command register.
// - Eight-bit index register addresses lookup and overlay, data bit 0 is LSB.
// - Red, green, blue writes merge into one 24-bit lookup entry after blue.
// - After a stored triplet the index advances by one.
// - Loading the index in read mode preloads holding registers, then advances.
// - After each blue read the holding registers reload and the index advances.
// - Overlay writes merge three bytes after blue, store, then advance.
// - Loading the index in overlay read mode preloads from the overlay entry.
// - Each blue overlay read reloads holding registers and advances the index.
// - Blue access at lookup location FF wraps the index to 00.
// - Overlay accesses use only the low index nibble.
// - Storage transfers happen in the idle cycle after a host access.
// - Hidden modulo-three phase counter, cleared by index writes, unreadable.
// - Reading the index changes neither index, phase nor mode.
// - Command bit chooses 8-bit or 6-bit color transfers.
// - In 6-bit transfers bits 7 and 6 are dropped on writes, zero on reads.
// - In 6-bit mode the two converter LSBs are forced to zero.
// - Compatibility pin low forces red pseudo color, no pedestal, 6-bit output.
// - Compatibility pin low overrides the format selects.
// - Mode comes from format selects and channel bits; selects are pipelined.
// - Pseudo format picks red, green or blue index, or 15-bit true color.
`include "palhap_consts.svh"

module palhap_port (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [2:0] regSelect,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  input wire logic [7:0] pixRed,
  input wire logic [7:0] pixGreen,
  input wire logic [7:0] pixBlue,
  input wire logic [3:0] overlayIndexIn,
  input wire logic formatSelect0,
  input wire logic formatSelect1,
  input wire logic compatModeN,
  output palhap_pkg::palhap_rgb_t dacOut,
  output logic pedestalEnable,
  output logic dacSixBit
);
  import palhap_pkg::*;

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rstMeta_r;
  logic rstN;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  // --------------------------------------------------------------------------
  // Host select decode
  // --------------------------------------------------------------------------
  logic [7:0] index_r;
  logic [7:0] mask_r;
  logic [7:0] cmd_r;
  palhap_phase_t phase_r;
  palhap_phase_t phaseNxt;
  palhap_mode_t mode_r;
  palhap_rgb_t hold_r;
  palhap_rgb_t triplet_r;
  logic storePending_r;
  logic storeOvl_r;
  logic loadPending_r;
  logic loadOvl_r;
  palhap_rgb_t lut [0:255];
  palhap_rgb_t ovl [1:15];

  wire selAddrWr = regSelect == `PALHAP_SEL_ADDR_RAM_WR
    || regSelect == `PALHAP_SEL_ADDR_OVL_WR;
  wire selAddrRd = regSelect == `PALHAP_SEL_ADDR_RAM_RD
    || regSelect == `PALHAP_SEL_ADDR_OVL_RD;
  wire selAddr = selAddrWr | selAddrRd;
  wire selLut = regSelect == `PALHAP_SEL_LUT;
  wire selOvl = regSelect == `PALHAP_SEL_OVL;
  wire selColor = selLut | selOvl;
  wire selMask = regSelect == `PALHAP_SEL_MASK;
  wire selCmd = regSelect == `PALHAP_SEL_CMD;
  wire addrLoad = hostWrite & selAddr;
  wire colorWrite = hostWrite & selColor;
  wire colorRead = hostRead & selColor;
  wire blueDone = (colorWrite | colorRead) & (phase_r == PH_BLUE);
  wire advance = storePending_r | loadPending_r;

  // Pin low forces 6-bit transfers too, so legacy software sees its own width.
  wire sixBit = ~cmd_r[`PALHAP_CMD_EIGHT_BIT] | ~compatModeN;
  wire [7:0] wrByte = sixBit ? {hostDataIn[5:0], 2'b00} : hostDataIn;

  // --------------------------------------------------------------------------
  // Triplet phase counter
  // --------------------------------------------------------------------------
  always_comb
  begin
    case (phase_r)
      PH_RED: phaseNxt = PH_GREEN;
      PH_GREEN: phaseNxt = PH_BLUE;
      PH_BLUE: phaseNxt = PH_RED;
      default: phaseNxt = PH_RED;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      phase_r <= PH_RED;
    else if (addrLoad)
      phase_r <= PH_RED;
    else if (colorWrite | colorRead)
      phase_r <= phaseNxt;
  end

  // --------------------------------------------------------------------------
  // Index register and access mode
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      index_r <= `PALHAP_INDEX_RESET;
      mode_r <= '0;
    end
    else if (addrLoad)
    begin
      index_r <= hostDataIn;
      mode_r.overlay <= regSelect[`PALHAP_SEL_OVL_BIT];
      mode_r.readMode <= selAddrRd;
    end
    else if (advance)
      index_r <= index_r + `PALHAP_INDEX_STEP;
  end

  // --------------------------------------------------------------------------
  // Deferred storage transfers
  // --------------------------------------------------------------------------
  // A transfer runs in the cycle after the access, so the host must leave one
  // idle cycle between accesses; the pixel path never waits on the host.
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      storePending_r <= 1'b0;
      storeOvl_r <= 1'b0;
      loadPending_r <= 1'b0;
      loadOvl_r <= 1'b0;
      triplet_r <= '0;
    end
    else
    begin
      storePending_r <= colorWrite & (phase_r == PH_BLUE) & ~addrLoad;
      storeOvl_r <= selOvl;
      loadPending_r <= (hostWrite & selAddrRd) | (colorRead & (phase_r == PH_BLUE));
      loadOvl_r <= (hostWrite & selAddrRd) ? regSelect[`PALHAP_SEL_OVL_BIT] : selOvl;
      if (colorWrite)
      begin
        case (phase_r)
          PH_RED: triplet_r.red <= wrByte;
          PH_GREEN: triplet_r.green <= wrByte;
          PH_BLUE: triplet_r.blue <= wrByte;
          default: triplet_r <= triplet_r;
        endcase
      end
    end
  end

  wire ovlSlotValid = index_r[3:0] != `PALHAP_OVL_NONE;
  wire palhap_rgb_t ovlEntry = ovlSlotValid ? ovl[index_r[3:0]] : '0;

  always_ff @(posedge ref_clk)
  begin
    if (storePending_r && !storeOvl_r)
      lut[index_r] <= triplet_r;
    if (storePending_r && storeOvl_r && ovlSlotValid)
      ovl[index_r[3:0]] <= triplet_r;
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
      hold_r <= '0;
    else if (loadPending_r)
      hold_r <= loadOvl_r ? ovlEntry : lut[index_r];
  end

  // --------------------------------------------------------------------------
  // Mask and command registers, read data
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mask_r <= `PALHAP_MASK_RESET;
      cmd_r <= `PALHAP_CMD_RESET;
    end
    else
    begin
      if (hostWrite && selMask)
        mask_r <= hostDataIn;
      if (hostWrite && selCmd)
        cmd_r <= hostDataIn;
    end
  end

  wire [7:0] holdByte = (phase_r == PH_RED) ? hold_r.red
    : (phase_r == PH_GREEN) ? hold_r.green : hold_r.blue;
  wire [7:0] rdColor = sixBit ? {2'b00, holdByte[7:2]} : holdByte;
  wire [7:0] rdData = selAddr ? index_r
    : selColor ? rdColor
    : selMask ? mask_r : cmd_r;

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      hostDataOut <= 8'h00;
      hostDataOe <= 1'b0;
    end
    else
    begin
      hostDataOe <= hostRead;
      if (hostRead)
        hostDataOut <= rdData;
    end
  end

  // --------------------------------------------------------------------------
  // Pixel path
  // --------------------------------------------------------------------------
  palhap_rgb_t pix_r;
  logic [3:0] ovlIdx_r;
  logic [1:0] fmt_r;

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pix_r <= '0;
      ovlIdx_r <= `PALHAP_OVL_NONE;
      fmt_r <= `PALHAP_FMT_TRUE24;
    end
    else
    begin
      pix_r <= {pixRed, pixGreen, pixBlue};
      ovlIdx_r <= overlayIndexIn;
      fmt_r <= {formatSelect1, formatSelect0};
    end
  end

  wire [1:0] fmt = compatModeN ? fmt_r : `PALHAP_FMT_PSEUDO;
  wire [1:0] chan = compatModeN
    ? {cmd_r[`PALHAP_CMD_CHAN_HI], cmd_r[`PALHAP_CMD_CHAN_LO]} : `PALHAP_CHAN_RED;
  wire wide15 = chan == `PALHAP_CHAN_WIDE15;
  wire [7:0] pickByte = (chan == `PALHAP_CHAN_RED) ? pix_r.red
    : (chan == `PALHAP_CHAN_GREEN) ? pix_r.green : pix_r.blue;
  wire [7:0] pseudoIdx = pickByte & mask_r;
  wire [7:0] wideR = {pix_r.red[6:2], 3'h0};
  wire [7:0] wideG = {pix_r.red[1:0], pix_r.green[7:5], 3'h0};
  wire [7:0] wideB = {pix_r.green[4:0], 3'h0};
  wire isPseudo = fmt == `PALHAP_FMT_PSEUDO;
  wire [7:0] idxR = (fmt == `PALHAP_FMT_TRUE24) ? (pix_r.red & mask_r)
    : wide15 ? wideR : pseudoIdx;
  wire [7:0] idxG = (fmt == `PALHAP_FMT_TRUE24) ? (pix_r.green & mask_r)
    : wide15 ? wideG : pseudoIdx;
  wire [7:0] idxB = (fmt == `PALHAP_FMT_TRUE24) ? (pix_r.blue & mask_r)
    : wide15 ? wideB : pseudoIdx;
  wire palhap_rgb_t lutColor = '{lut[idxR].red, lut[idxG].green, lut[idxB].blue};
  wire palhap_rgb_t by8 = '{{pickByte[7:5], 5'h00}, {pickByte[4:2], 5'h00},
    {pickByte[1:0], 6'h00}};
  wire palhap_rgb_t by15 = '{wideR, wideG, wideB};
  wire reservedMode = wide15 & (fmt == `PALHAP_FMT_TRUE24 || fmt == `PALHAP_FMT_BYPASS24);

  palhap_rgb_t pixColor;
  always_comb
  begin
    if (ovlIdx_r != `PALHAP_OVL_NONE)
      pixColor = ovl[ovlIdx_r];
    else if (reservedMode)
      pixColor = '0;
    else if (fmt == `PALHAP_FMT_BYPASS24)
      pixColor = pix_r;
    else if (fmt == `PALHAP_FMT_BYPASS8)
      pixColor = wide15 ? by15 : by8;
    else
      pixColor = lutColor;
  end

  wire [7:0] lowMask = sixBit ? 8'hFC : 8'hFF;

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      dacOut <= '0;
      pedestalEnable <= 1'b0;
      dacSixBit <= 1'b0;
    end
    else
    begin
      dacOut <= pixColor & {lowMask, lowMask, lowMask};
      pedestalEnable <= cmd_r[`PALHAP_CMD_PEDESTAL] & compatModeN;
      dacSixBit <= sixBit;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  chk_triplet_advance: assert property (
    colorWrite && phase_r == PH_BLUE |=> ##1 index_r == $past(index_r, 2) + 8'h01)
    else $error("Index did not advance after a stored triplet.");
  chk_triplet_store: assert property (
    colorWrite && selLut && phase_r == PH_BLUE ##1 1'b1
    |=> lut[$past(index_r, 2)] == $past(triplet_r))
    else $error("Lookup entry does not hold the written triplet.");
  chk_read_preload: assert property (
    hostWrite && regSelect == `PALHAP_SEL_ADDR_RAM_RD
    |=> ##1 index_r == $past(hostDataIn, 2) + 8'h01 && hold_r == lut[$past(hostDataIn, 2)])
    else $error("Read-mode index load did not preload and advance.");
  chk_wrap_index: assert property (
    blueDone && selLut && index_r == `PALHAP_INDEX_LAST |=> ##1 index_r == 8'h00)
    else $error("Index failed to wrap after location FF.");
  chk_ovl_nibble: assert property (
    storePending_r && storeOvl_r && ovlSlotValid
    |=> ovl[$past(index_r[3:0])] == $past(triplet_r))
    else $error("Overlay store missed the low-nibble entry.");
  chk_phase_clear: assert property (
    addrLoad |=> phase_r == PH_RED && !storePending_r)
    else $error("Index write did not clear the phase or abandon the triplet.");
  chk_addr_read_quiet: assert property (
    hostRead && selAddr && !advance
    |=> $stable(index_r) && $stable(phase_r) && $stable(mode_r) && hostDataOut == $past(index_r))
    else $error("Index read disturbed state or returned the wrong value.");
  chk_six_bit_read: assert property (
    colorRead && sixBit |=> hostDataOut[7:6] == 2'b00)
    else $error("Upper color bits not zero in 6-bit reads.");
  chk_dac_low_bits: assert property (
    sixBit |=> dacOut.red[1:0] == 2'b00 && dacOut.green[1:0] == 2'b00 && dacOut.blue[1:0] == 2'b00)
    else $error("Converter LSBs not forced in 6-bit mode.");
  chk_compat_force: assert property (
    !compatModeN |=> !pedestalEnable && dacSixBit)
    else $error("Compatibility pin did not force pedestal and width.");

  cov_block_write: cover property (colorWrite && phase_r == PH_BLUE ##3 colorWrite);
  cov_ram_readback: cover property (hostWrite && selAddrRd ##3 colorRead ##3 colorRead ##3 colorRead);
  cov_ovl_store: cover property (storePending_r && storeOvl_r && ovlSlotValid);
  cov_index_wrap: cover property (advance && index_r == `PALHAP_INDEX_LAST);

endmodule // palhap_port

// >>> verif/palhap_host_model.sv
module palhap_host_model (
  input wire logic ref_clk,
  output logic [2:0] regSelect,
  output logic hostWrite,
  output logic hostRead,
  output logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    regSelect = 3'h0;
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostDataIn = 8'h00;
  end

  // Strobes move at falling edges, so exactly one rising edge takes each access.
  task automatic write(input logic [2:0] sel, input logic [7:0] data);
    @(negedge ref_clk);
    regSelect = sel;
    hostDataIn = data;
    hostWrite = 1'b1;
    @(negedge ref_clk);
    hostWrite = 1'b0;
    hostDataIn = ~data;
    @(negedge ref_clk);
  endtask

  task automatic read(input logic [2:0] sel, output logic [7:0] data, output logic oe);
    @(negedge ref_clk);
    regSelect = sel;
    hostRead = 1'b1;
    @(negedge ref_clk);
    hostRead = 1'b0;
    data = hostDataOut;
    oe = hostDataOe;
    @(negedge ref_clk);
  endtask
endmodule // palhap_host_model

// >>> verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import palhap_pkg::*;

  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] regSelect;
  logic hostWrite;
  logic hostRead;
  logic [7:0] hostDataIn;
  logic [7:0] hostDataOut;
  logic hostDataOe;
  logic [7:0] pixRed = 8'h00;
  logic [7:0] pixGreen = 8'h00;
  logic [7:0] pixBlue = 8'h00;
  logic [3:0] overlayIndexIn = 4'h0;
  logic formatSelect0 = 1'b0;
  logic formatSelect1 = 1'b0;
  logic compatModeN = 1'b1;
  palhap_rgb_t dacOut;
  logic pedestalEnable;
  logic dacSixBit;
  int failures = 0;
  int checkCount = 0;
  int seed = 32'hACB88F89;
  int lut[256];
  int ovl[16];
  int hold = 0;
  int wacc = 0;
  int idx = 0;
  int ph = 0;
  int mask = 255;
  int cmd = 0;

  always #5 ref_clk = ~ref_clk;

  palhap_port i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .regSelect(regSelect),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .pixRed(pixRed),
    .pixGreen(pixGreen), .pixBlue(pixBlue), .overlayIndexIn(overlayIndexIn),
    .formatSelect0(formatSelect0), .formatSelect1(formatSelect1),
    .compatModeN(compatModeN), .dacOut(dacOut), .pedestalEnable(pedestalEnable),
    .dacSixBit(dacSixBit));

  palhap_host_model i_host (.ref_clk(ref_clk), .regSelect(regSelect),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe));

  // ---------------------------------------------------------------------------
  // Compare and closing
  // ---------------------------------------------------------------------------
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp24(input string what, input logic [23:0] exp, input logic [23:0] got);
    checkCount++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Reference model of the host port
  // ---------------------------------------------------------------------------
  function automatic int fetch(input bit ovlSel);
    if (ovlSel)
      return ovl[idx % 16];
    return lut[idx];
  endfunction

  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    int v;
    i_host.write(sel, d);
    v = (cmd[1] && compatModeN) ? d : (d & 8'h3F) << 2;
    case (sel)
      3'h1, 3'h5:
      begin
        wacc = (wacc << 8) | v;
        ph = ph + 1;
        if (ph == 3)
        begin
          if (!sel[2])
            lut[idx] = wacc & 24'hFFFFFF;
          else if (idx % 16 != 0)
            ovl[idx % 16] = wacc & 24'hFFFFFF;
          idx = (idx + 1) % 256;
          ph = 0;
        end
      end
      3'h2: mask = d;
      3'h6: cmd = d;
      default:
      begin
        idx = d;
        ph = 0;
        if (sel[1:0] == 2'h3)
        begin
          hold = fetch(sel[2]);
          idx = (idx + 1) % 256;
        end
      end
    endcase
  endtask

  task automatic rd(input logic [2:0] sel, input string what);
    logic [7:0] got;
    logic oe;
    int e;
    i_host.read(sel, got, oe);
    case (sel)
      3'h1, 3'h5:
      begin
        e = (hold >> (16 - 8 * ph)) & 8'hFF;
        if (!(cmd[1] && compatModeN))
          e = e >> 2;
        ph = ph + 1;
        if (ph == 3)
        begin
          ph = 0;
          hold = fetch(sel[2]);
          idx = (idx + 1) % 256;
        end
      end
      3'h2: e = mask;
      3'h6: e = cmd;
      default: e = idx;
    endcase
    cmp8(what, 8'(e), got);
    cmp8("hostDataOe", 8'h01, {7'h00, oe});
  endtask

  // The converter inputs follow the pixel inputs two rising edges later.
  task automatic pix(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b,
      input logic [3:0] o, input logic [1:0] f, input int e);
    @(negedge ref_clk);
    pixRed = r;
    pixGreen = g;
    pixBlue = b;
    overlayIndexIn = o;
    {formatSelect1, formatSelect0} = f;
    repeat (3) @(negedge ref_clk);
    cmp24("dacOut", 24'(e), dacOut);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    int a;
    int e24;
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (int s = 0; s < 8; s++)
      if (s != 1 && s != 5)
        rd(3'(s), "reset");
    $display("test reset done");
    a = $random(seed) & 8'hFF;
    wr(3'h0, 8'(a));
    repeat (6) wr(3'h1, 8'($random(seed)));
    wr(3'h3, 8'(a));
    repeat (6) rd(3'h1, "lut6");
    rd(3'h0, "index");
    $display("test six bit done");
    wr(3'h6, 8'h02);
    wr(3'h0, 8'hFE);
    repeat (9) wr(3'h1, 8'($random(seed)));
    rd(3'h4, "wrap");
    wr(3'h3, 8'hFE);
    repeat (9) rd(3'h1, "lut8");
    rd(3'h7, "index");
    $display("test wrap done");
    wr(3'h0, 8'h40);
    repeat (3) wr(3'h1, 8'($random(seed)));
    wr(3'h0, 8'h40);
    repeat (2) wr(3'h1, 8'($random(seed)));
    wr(3'h0, 8'h41);
    repeat (4) wr(3'h1, 8'($random(seed)));
    rd(3'h3, "index");
    repeat (2) wr(3'h1, 8'($random(seed)));
    wr(3'h3, 8'h40);
    repeat (9) rd(3'h1, "abandon");
    $display("test abandon done");
    wr(3'h4, 8'hF3);
    repeat (6) wr(3'h5, 8'($random(seed)));
    wr(3'h4, 8'h00);
    repeat (3) wr(3'h5, 8'($random(seed)));
    wr(3'h7, 8'hA3);
    repeat (6) rd(3'h5, "overlay");
    wr(3'h7, 8'h50);
    repeat (3) rd(3'h5, "overlay0");
    $display("test overlay done");
    wr(3'h2, 8'hF0);
    for (int c = 0; c < 3; c++)
    begin
      wr(3'h6, 8'(c << 6) | 8'h02);
      pix(c == 0 ? 8'h4D : 8'h00, c == 1 ? 8'h4D : 8'h00, c == 2 ? 8'h4D : 8'h00, 4'h0,
        2'h2, lut[8'h40]);
    end
    // Red and blue fall on entry 40 after masking, green on entry 00.
    e24 = (lut[8'h40] & 24'hFF00FF) | (lut[8'h00] & 24'h00FF00);
    pix(8'h4D, 8'h0F, 8'h4F, 4'h0, 2'h0, e24);
    pix(8'h00, 8'h00, 8'hB6, 4'h0, 2'h3, 24'hA0A080);
    pix(8'h12, 8'h34, 8'h56, 4'h0, 2'h1, 24'h123456);
    pix(8'h00, 8'h00, 8'h00, 4'h3, 2'h1, ovl[3]);
    wr(3'h6, 8'hC2);
    pix(8'h12, 8'h34, 8'h56, 4'h0, 2'h1, 24'h000000);
    pix(8'h20, 8'h08, 8'h00, 4'h0, 2'h2, e24);
    wr(3'h6, 8'h00);
    pix(8'hFF, 8'hFF, 8'hFF, 4'h0, 2'h1, 24'hFCFCFC);
    cmp8("dacSixBit", 8'h01, {7'h00, dacSixBit});
    wr(3'h6, 8'h03);
    pix(8'h12, 8'h34, 8'h56, 4'h0, 2'h1, 24'h123456);
    cmp8("pedestalEnable", 8'h01, {7'h00, pedestalEnable});
    compatModeN = 1'b0;
    pix(8'h4D, 8'h00, 8'h00, 4'h0, 2'h1, lut[8'h40] & 24'hFCFCFC);
    cmp8("pedestalEnable", 8'h00, {7'h00, pedestalEnable});
    cmp8("dacSixBit", 8'h01, {7'h00, dacSixBit});
    wr(3'h3, 8'h40);
    repeat (3) rd(3'h1, "compat");
    $display("test pixel done");
    // The storage arrays keep their contents, only the registers return to reset.
    reset_n = 1'b0;
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    idx = 0;
    ph = 0;
    hold = 0;
    mask = 255;
    cmd = 0;
    for (int s = 0; s < 8; s++)
      if (s != 1 && s != 5)
        rd(3'(s), "rereset");
    cmp8("dacSixBit", 8'h01, {7'h00, dacSixBit});
    $display("test mid reset done");
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
endmodule // tb_top
